// ### bench/tmc_pulse_gen.sv
`timescale 1ns/1ns
`default_nettype none
module tmc_pulse_gen
(
  input wire logic clk_i,
  input wire logic run_i,
  input wire logic [7:0] half_i,
  output logic pulse_o
);
  logic [7:0] cnt_reg;
  initial
  begin
    cnt_reg = 8'h00;
    pulse_o = 1'b0;
  end
  // clean square wave, slow enough for the contact filter
  always @(posedge clk_i)
  begin
    if (!run_i)
    begin
      cnt_reg <= 8'h00;
      pulse_o <= 1'b0;
    end
    else if (cnt_reg == half_i - 8'h01)
    begin
      cnt_reg <= 8'h00;
      pulse_o <= !pulse_o;
    end
    else
      cnt_reg <= cnt_reg + 8'h01;
  end
endmodule
`default_nettype wire

// ### bench/tmc_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "tmc_regs.svh"
module tmc_top_tb;
  import tmc_pkg::*;
  logic clk_i, rst_n_i, rd, wr, waitreq, run, prot;
  logic red, green, led, tr, ct, pulse;
  logic [2:0] addr, dp;
  logic [31:0] wdata, rdata;
  logic [7:0] dip;
  logic [23:0] val, sv1;
  tmc_keys_t keys, keys_o;
  logic [31:0] exp_q[$];
  logic [4:0] mask[1:5] = '{5'h01, 5'h05, 5'h09, 5'h0d, 5'h1d};
  int n_fail = 0;
  int comparisons = 0;

  tmc_top #(.SAMPLE_CYC(200), .TENTH_CYC(100), .FILT_CYC(4)) i_tmc_top (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .pulse_input_one_i(pulse), .keys_i(keys),
    .protect_sw_i(prot), .dip_i(dip), .keys_o(keys_o), .transistor_o(tr), .contact_o(ct), .red_o(red),
    .green_o(green), .protect_led_o(led), .decimal_point_position_o(dp), .value_o(val));
  tmc_pulse_gen i_tmc_pulse_gen (.clk_i(clk_i), .run_i(run), .half_i(8'd10), .pulse_o(pulse));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // read data is only valid in the one cycle waitrequest is low
  always @(posedge clk_i)
    if (rd && waitreq === 1'b0 && exp_q.size() > 0)
      check(rdata, exp_q.pop_front());

  task automatic bus(input logic w, input logic [2:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clk_i);
      if (waitreq === 1'b0)
        break;
    end
    if (i == 20)
    begin
      check({31'h0, waitreq}, 32'h0);
      test_done();
    end
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [31:0] exp);
    exp_q.push_back(exp);
    bus(1'b0, a, 32'h0);
  endtask

  task automatic wait_val(input logic [23:0] exp, input int lim);
    int i;
    for (i = 0; i < lim; i++)
    begin
      @(posedge clk_i);
      if (val === exp)
        break;
    end
    check({8'h00, val}, {8'h00, exp});
    if (i == lim)
      test_done();
  endtask

  task automatic power_up(input logic [7:0] d);
    rst_n_i <= 1'b0;
    dip <= d;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    // switches latch on the third edge after release
    repeat (4) @(posedge clk_i);
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    {rd, wr, run, prot} = 4'h0;
    addr = 3'h0;
    wdata = 32'h0;
    keys = '0;
    dip = 8'h41;
    void'($urandom(32'h8762be03));
    power_up(8'h41);
    rd_chk(`TMC_A_PRESCALE, 32'h100);
    rd_chk(`TMC_A_TIMES, 32'ha);
    rd_chk(`TMC_A_DISP, 32'h40);
    rd_chk(`TMC_A_CTRL, 32'h50);
    $display("reset values done");
    sv1 = 24'($urandom_range(50, 1));
    bus(1'b1, `TMC_A_SV1, {8'h0, sv1});
    rd_chk(`TMC_A_SV1, {8'h0, sv1});
    run <= 1'b1;
    wait_val(24'd50, 1000);
    rd_chk(`TMC_A_VALUE, 32'h0100_0032);
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, `TMC_A_DISP, 32'h40 | c);
      repeat (4) @(posedge clk_i);
      check({30'h0, red, green}, (c == 1 || c == 2) ? 32'h1 : 32'h2);
      check({30'h0, tr, ct}, 32'h2);
    end
    bus(1'b1, `TMC_A_DISP, 32'h6e);
    repeat (4) @(posedge clk_i);
    check({29'h0, dp}, 32'h3);
    check({30'h0, tr, ct}, 32'h1);
    $display("outputs and colour done");
    bus(1'b1, `TMC_A_PRESCALE, 32'h200);
    bus(1'b1, `TMC_A_CTRL, 32'h58);
    wait_val(24'd100, 1000);
    bus(1'b1, `TMC_A_CTRL, 32'h50);
    wait_val(24'd50, 1000);
    $display("prescale done");
    bus(1'b1, `TMC_A_CTRL, 32'h51);
    wait_val(24'd0, 10);
    repeat (4) @(posedge clk_i);
    check({30'h0, tr, ct}, 32'h0);
    bus(1'b1, `TMC_A_CTRL, 32'h52);
    wait_val(24'd50, 1000);
    rd_chk(`TMC_A_SV1, {8'h0, sv1});
    // a real configuration change must clear the setpoints
    bus(1'b1, `TMC_A_CTRL, 32'h01);
    bus(1'b1, `TMC_A_CTRL, 32'h02);
    rd_chk(`TMC_A_SV1, 32'h0);
    bus(1'b1, `TMC_A_CTRL, 32'h51);
    bus(1'b1, `TMC_A_CTRL, 32'h52);
    $display("config mode done");
    run <= 1'b0;
    wait_val(24'd0, 2000);
    $display("auto zero done");
    // mode key is blocked at every level, so holding all keys never changes mode
    prot <= 1'b1;
    keys <= 5'h1f;
    for (int lv = 1; lv <= 5; lv++)
    begin
      bus(1'b1, `TMC_A_DISP, 32'h2 | (lv << 6));
      repeat (5) @(posedge clk_i);
      check({27'h0, keys_o}, {27'h0, 5'h1f & ~mask[lv]});
      check({31'h0, led}, 32'h1);
    end
    prot <= 1'b0;
    keys <= '0;
    $display("key protect done");
    repeat (4) @(posedge clk_i);
    keys <= 5'h03;
    repeat (1200) @(posedge clk_i);
    rd_chk(`TMC_A_STATUS, 32'h00aa4141);
    keys <= '0;
    repeat (4) @(posedge clk_i);
    bus(1'b1, `TMC_A_CTRL, 32'h52);
    $display("key hold done");
    power_up(8'h6b);
    dip <= 8'h41;
    run <= 1'b1;
    wait_val(24'd50, 2000);
    rd_chk(`TMC_A_VALUE, 32'h0300_0032);
    rd_chk(`TMC_A_STATUS, 32'h00b9416b);
    bus(1'b1, `TMC_A_TIMES, 32'h2);
    run <= 1'b0;
    // four-window averaging alone would take longer than this bound
    wait_val(24'd0, 400);
    $display("slow averaged input done");
    power_up(8'h51);
    bus(1'b1, `TMC_A_SV1, 32'ha);
    bus(1'b1, `TMC_A_SV2, 32'h64);
    bus(1'b1, `TMC_A_DISP, 32'h2);
    run <= 1'b1;
    wait_val(24'd50, 1000);
    repeat (4) @(posedge clk_i);
    check({28'h0, tr, ct, red, green}, 32'h9);
    bus(1'b1, `TMC_A_SV2, 32'h28);
    repeat (4) @(posedge clk_i);
    check({28'h0, tr, ct, red, green}, 32'h6);
    power_up(8'h71);
    wait_val(24'd50, 1000);
    rd_chk(`TMC_A_VALUE, 32'h32);
    $display("output modes done");
    test_done();
  end
endmodule
`default_nettype wire

// ### core/tmc_filter.sv
`timescale 1ns/1ns
`default_nettype none
module tmc_filter
#(
  parameter int STABLE_CYC = 100000
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);
  localparam int CW = $clog2(STABLE_CYC + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic lvl;
  } tmc_filt_st_t;

  tmc_filt_st_t s_reg;
  tmc_filt_st_t s_next;

  // a level must hold for the whole count; contact bounce restarts it
  always_comb
  begin
    s_next = s_reg;
    if (d_i == s_reg.lvl)
      s_next.cnt = '0;
    else if (s_reg.cnt == CW'(STABLE_CYC - 1))
    begin
      s_next.cnt = '0;
      s_next.lvl = d_i;
    end
    else
      s_next.cnt = s_reg.cnt + CW'(1);
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign q_o = s_reg.lvl;
endmodule
`default_nettype wire

// ### core/tmc_pkg.sv
package tmc_pkg;

  typedef enum logic [2:0] {
    TMC_RUN = 3'b001,
    TMC_CFG = 3'b010,
    TMC_FUNC = 3'b100
  } tmc_mode_t;

  typedef enum logic [1:0] {
    TMC_RED = 2'h0,
    TMC_GREEN = 2'h1,
    TMC_DYN = 2'h2,
    TMC_DYN_INV = 2'h3
  } tmc_colour_t;

  typedef enum logic [1:0] {
    TMC_UPPER_LOWER_LIMIT_MODE = 2'h0,
    TMC_AREA = 2'h1,
    TMC_UPPER_UPPER_LIMIT_MODE = 2'h2,
    TMC_LOWER_LOWER_LIMIT_MODE = 2'h3
  } tmc_outmode_t;

  typedef struct packed {
    logic disp;
    logic updown;
    logic rst;
    logic second;
    logic mode;
  } tmc_keys_t;

  typedef struct packed {
    logic spare;
    logic pnp;
    tmc_outmode_t omode;
    logic [1:0] avg;
    logic slow;
    logic enable;
  } tmc_dip_t;

endpackage

// ### core/tmc_regs.svh
`ifndef TMC_REGS_SVH
`define TMC_REGS_SVH

// timing base
`define TMC_CLK_KHZ 50000
`define TMC_SAMPLE_MS 200
`define TMC_TENTH_MS 100
`define TMC_FILT_MS 2
`define TMC_HZ_PER_COUNT (1000 / `TMC_SAMPLE_MS)
`define TMC_CFG_HOLD_TENTHS 10'd10
`define TMC_FUNC_HOLD_TENTHS 10'd30

// word addresses
`define TMC_A_CTRL 3'h0
`define TMC_A_PRESCALE 3'h1
`define TMC_A_SV1 3'h2
`define TMC_A_SV2 3'h3
`define TMC_A_TIMES 3'h4
`define TMC_A_DISP 3'h5
`define TMC_A_STATUS 3'h6
`define TMC_A_VALUE 3'h7

// ctrl fields
`define TMC_CTRL_ENTER 0
`define TMC_CTRL_EXIT 1
`define TMC_CTRL_FUNC_CLR 2
`define TMC_CTRL_PRE_EN 3
`define TMC_CTRL_CFG_LSB 4
// times fields
`define TMC_TIMES_ZT_LSB 0
`define TMC_TIMES_ST_LSB 16
// disp fields
`define TMC_DISP_COL_LSB 0
`define TMC_DISP_DP_LSB 2
`define TMC_DISP_ALLOC 5
`define TMC_DISP_LOCK_LSB 6

// reset values
`define TMC_PRESCALE_RST 16'h0100
`define TMC_ZT_RST 10'h00a
`define TMC_ST_RST 10'h000
`define TMC_LOCK_RST 3'h1
`define TMC_CFG_TACH 3'h5
`define TMC_DIP_RST 8'h01

`endif

// ### core/tmc_sync.sv
`timescale 1ns/1ns
`default_nettype none
module tmc_sync
#(
  parameter int W = 1
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } tmc_sync_st_t;

  tmc_sync_st_t s_reg;
  tmc_sync_st_t s_next;

  always_comb
  begin
    s_next.meta = d_i;
    s_next.q = s_reg.meta;
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign q_o = s_reg.q;
endmodule
`default_nettype wire

// ### core/tmc_top.sv
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "tmc_regs.svh"
// Functional notes
// [R1] pulse input speed 30 Hz or 10 kHz
// [R2] contacts should use the 30 Hz setting
// [R3] one decimal point for value and setpoints
// [R4] value is frequency times prescale factor
// [R5] no prescaling shows raw hertz
// [R6] averaging none, 2, 4 or 8
// [R7] measurement cycle is 200 ms times count
// [R8] no pulse within zero timeout forces zero
// [R9] startup time blanks measurement and outputs
// [R10] one polarity setting for all inputs
// [R11] red, green or dynamic colour
// [R12] inverse dynamic colour mode
// [R13] area mode colour follows output one only
// [R14] allocation swaps transistor and contact stages
// [R15] protect switch lights indicator, blocks keys
// [R16] protect levels one to five block sets
// [R17] operator holds keys 1 s or 3 s
// [R18] config entry clears value, outputs, measuring
// [R19] config changes apply on return to run
// [R20] config change clears both setpoints
// [R21] monitor shows selector switch states
// [R22] four tachometer output modes
// [R23] selector switches latched only at power-up
// [R24] edges counted per 200 ms window
// [R25] outputs and value held until first cycle
module tmc_top
  import tmc_pkg::*;
#(
  parameter int SAMPLE_CYC = `TMC_SAMPLE_MS * `TMC_CLK_KHZ,
  parameter int TENTH_CYC = `TMC_TENTH_MS * `TMC_CLK_KHZ,
  parameter int FILT_CYC = `TMC_FILT_MS * `TMC_CLK_KHZ
)(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic pulse_input_one_i,
  input wire tmc_keys_t keys_i,
  input wire logic protect_sw_i,
  input wire logic [7:0] dip_i,
  output tmc_keys_t keys_o,
  output logic transistor_o,
  output logic contact_o,
  output logic red_o,
  output logic green_o,
  output logic protect_led_o,
  output logic [2:0] decimal_point_position_o,
  output logic [23:0] value_o
);
  localparam int WIN_W = $clog2(SAMPLE_CYC + 1);
  localparam int TEN_W = $clog2(TENTH_CYC + 1);

  typedef struct packed {
    tmc_mode_t mode;
    logic [1:0] boot;
    tmc_dip_t dip;
    logic [2:0] cur_cfg;
    logic [2:0] pend_cfg;
    logic pre_en;
    logic [15:0] prescale;
    logic [9:0] zt;
    logic [9:0] st;
    tmc_colour_t colour;
    logic [2:0] dp;
    logic alloc;
    logic [2:0] lock;
    logic [23:0] sv1;
    logic [23:0] sv2;
    logic [WIN_W-1:0] win_cnt;
    logic [TEN_W-1:0] tenth_cnt;
    logic [15:0] pulse_cnt;
    logic [18:0] sum;
    logic [2:0] nwin;
    logic [9:0] idle_t;
    logic [9:0] up_t;
    logic [9:0] hold_t;
    logic started;
    logic live;
    logic prev_pulse;
    logic [23:0] pv;
    logic control_output_one;
    logic control_output_two;
    logic trans;
    logic contact;
    logic red;
    logic green;
    logic led;
    tmc_keys_t keys;
    logic waitreq;
    logic [31:0] rdata;
  } tmc_state_t;

  tmc_state_t s_reg;
  tmc_state_t s_next;

  logic [14:0] sync_q;
  logic [7:0] dip_s;
  logic pulse_l;
  logic pulse_f;
  logic prot_l;
  tmc_keys_t keys_l;
  logic [3:0] blk;
  logic win_end;
  logic tenth;
  logic req;
  logic done;

  tmc_sync #(
    .W(15)
  ) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i({protect_sw_i, keys_i, pulse_input_one_i, dip_i}),
    .q_o(sync_q)
  );

  assign dip_s = sync_q[7:0];
  // npn inputs are active low at the pin
  assign pulse_l = sync_q[8] ~^ s_reg.dip.pnp; // see [R10]
  assign keys_l = tmc_keys_t'(sync_q[13:9] ^ {5{~s_reg.dip.pnp}}); // see [R10]
  assign prot_l = sync_q[14] ~^ s_reg.dip.pnp; // see [R10]

  tmc_filter #(
    .STABLE_CYC(FILT_CYC)
  ) u_filt (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .d_i(pulse_l),
    .q_o(pulse_f)
  );

  // blocked set per level: {disp, updown, reset, mode}
  always_comb
  begin
    case (s_reg.lock)
      3'h2: blk = 4'h3; // see [R16]
      3'h3: blk = 4'h5; // see [R16]
      3'h4: blk = 4'h7; // see [R16]
      3'h5: blk = 4'hf; // see [R16]
      default: blk = 4'h1; // see [R16]
    endcase
  end

  assign win_end = (s_reg.win_cnt == WIN_W'(SAMPLE_CYC - 1));
  assign tenth = (s_reg.tenth_cnt == TEN_W'(TENTH_CYC - 1));
  assign req = avs_read_i | avs_write_i;
  assign done = req & ~s_reg.waitreq;

  always_comb
  begin
    logic pq;
    logic edge_seen;
    logic meas;
    logic [15:0] pcnt;
    logic [18:0] sum_new;
    logic [21:0] freq;
    logic [37:0] prod;
    logic [23:0] scaled;
    logic [2:0] nlast;
    logic act;
    logic on;
    logic [2:0] newcfg;
    logic [31:0] rd;
    pq = 1'b0;
    edge_seen = 1'b0;
    meas = 1'b0;
    pcnt = '0;
    sum_new = '0;
    freq = '0;
    prod = '0;
    scaled = '0;
    nlast = '0;
    act = 1'b0;
    on = 1'b0;
    newcfg = '0;
    rd = '0;
    s_next = s_reg;

    // switches caught once, after the synchroniser has filled
    if (s_reg.boot != 2'h3)
      s_next.boot = s_reg.boot + 2'h1;
    if (s_reg.boot == 2'h2)
      s_next.dip = dip_s[0] ? tmc_dip_t'(dip_s) : tmc_dip_t'(`TMC_DIP_RST); // see [R23]

    s_next.tenth_cnt = tenth ? '0 : s_reg.tenth_cnt + TEN_W'(1);

    // bounce filter only on the slow setting; fast edges pass raw
    pq = s_reg.dip.slow ? pulse_f : pulse_l; // see [R1] [R2]
    edge_seen = pq & ~s_reg.prev_pulse;
    s_next.prev_pulse = pq;

    if (!s_reg.started && tenth)
      s_next.up_t = s_reg.up_t + 10'h1;
    if (s_reg.boot == 2'h3 && s_reg.up_t >= s_reg.st)
      s_next.started = 1'b1; // see [R9]

    meas = (s_reg.mode != TMC_CFG) && s_reg.started && (s_reg.cur_cfg == `TMC_CFG_TACH);
    if (!meas)
    begin
      s_next.win_cnt = '0;
      s_next.pulse_cnt = '0;
      s_next.sum = '0;
      s_next.nwin = '0;
      s_next.idle_t = '0;
    end
    else
    begin
      pcnt = s_reg.pulse_cnt + {15'h0, edge_seen}; // see [R24]
      if (edge_seen)
        s_next.idle_t = '0;
      else if (tenth && s_reg.idle_t != 10'h3ff)
        s_next.idle_t = s_reg.idle_t + 10'h1;
      if (win_end)
      begin
        s_next.win_cnt = '0;
        s_next.pulse_cnt = '0;
        sum_new = s_reg.sum + {3'h0, pcnt};
        nlast = 3'((4'h1 << s_reg.dip.avg) - 4'h1); // see [R6]
        if (s_reg.nwin == nlast)
        begin
          // sum of counts over 1..8 windows, scaled to pulses per second
          freq = (22'(sum_new) * 22'(`TMC_HZ_PER_COUNT)) >> s_reg.dip.avg; // see [R7] [R24]
          prod = 38'(freq) * 38'(s_reg.prescale);
          // prescale is 8.8 fixed point; saturate rather than wrap
          scaled = (|prod[37:32]) ? 24'hffffff : prod[31:8]; // see [R4]
          s_next.pv = s_reg.pre_en ? scaled : 24'(freq); // see [R4] [R5]
          s_next.live = 1'b1; // see [R25]
          s_next.sum = '0;
          s_next.nwin = '0;
        end
        else
        begin
          s_next.sum = sum_new;
          s_next.nwin = s_reg.nwin + 3'h1;
        end
      end
      else
      begin
        s_next.win_cnt = s_reg.win_cnt + WIN_W'(1);
        s_next.pulse_cnt = pcnt;
      end
      if (s_reg.zt != 10'h0 && s_reg.idle_t >= s_reg.zt)
        s_next.pv = '0; // see [R8]
    end
    if (!s_reg.started || s_reg.mode == TMC_CFG)
    begin
      s_next.pv = '0; // see [R9] [R18] [R25]
      s_next.live = 1'b0;
    end

    act = s_reg.live && s_reg.started && (s_reg.mode != TMC_CFG); // see [R9] [R18] [R25]
    case (s_reg.dip.omode) // see [R22]
      TMC_AREA:
      begin
        s_next.control_output_one = act && s_reg.pv >= s_reg.sv1 && s_reg.pv <= s_reg.sv2;
        s_next.control_output_two = act && !(s_reg.pv >= s_reg.sv1 && s_reg.pv <= s_reg.sv2);
      end
      TMC_UPPER_UPPER_LIMIT_MODE:
      begin
        s_next.control_output_one = act && s_reg.pv >= s_reg.sv1;
        s_next.control_output_two = act && s_reg.pv >= s_reg.sv2;
      end
      TMC_LOWER_LOWER_LIMIT_MODE:
      begin
        s_next.control_output_one = act && s_reg.pv <= s_reg.sv1;
        s_next.control_output_two = act && s_reg.pv <= s_reg.sv2;
      end
      default:
      begin
        s_next.control_output_one = act && s_reg.pv >= s_reg.sv1;
        s_next.control_output_two = act && s_reg.pv <= s_reg.sv2;
      end
    endcase
    s_next.trans = s_reg.alloc ? s_reg.control_output_two : s_reg.control_output_one; // see [R14]
    s_next.contact = s_reg.alloc ? s_reg.control_output_one : s_reg.control_output_two; // see [R14]

    on = (s_reg.dip.omode == TMC_AREA) ? s_reg.control_output_one : (s_reg.control_output_one | s_reg.control_output_two); // see [R13]
    case (s_reg.colour)
      TMC_GREEN: s_next.green = 1'b1; // see [R11]
      TMC_DYN: s_next.green = on; // see [R11]
      TMC_DYN_INV: s_next.green = ~on; // see [R12]
      default: s_next.green = 1'b0; // see [R11]
    endcase
    s_next.red = ~s_next.green;

    s_next.led = prot_l; // see [R15]
    s_next.keys = keys_l;
    if (prot_l)
    begin
      s_next.keys.mode = keys_l.mode & ~blk[0]; // see [R15] [R16]
      s_next.keys.rst = keys_l.rst & ~blk[1]; // see [R16]
      s_next.keys.updown = keys_l.updown & ~blk[2]; // see [R16]
      s_next.keys.disp = keys_l.disp & ~blk[3]; // see [R16]
    end

    // bus: one wait cycle, then the answer; writes land on the done edge
    if (req && s_reg.waitreq)
      s_next.waitreq = 1'b0;
    else
      s_next.waitreq = 1'b1;
    case (avs_address_i)
      `TMC_A_CTRL: rd = {25'h0, s_reg.pend_cfg, s_reg.pre_en, 3'h0};
      `TMC_A_PRESCALE: rd = {16'h0, s_reg.prescale};
      `TMC_A_SV1: rd = {8'h0, s_reg.sv1};
      `TMC_A_SV2: rd = {8'h0, s_reg.sv2};
      `TMC_A_TIMES: rd = {6'h0, s_reg.st, 6'h0, s_reg.zt};
      `TMC_A_DISP: rd = {23'h0, s_reg.lock, s_reg.alloc, s_reg.dp, s_reg.colour};
      `TMC_A_STATUS: rd = {7'h0, prot_l, s_reg.cur_cfg, s_reg.live, s_reg.started, s_reg.mode, dip_s,
                           s_reg.dip}; // see [R21]
      default: rd = {6'h0, s_reg.control_output_two, s_reg.control_output_one, s_reg.pv};
    endcase
    if (req && s_reg.waitreq)
      s_next.rdata = avs_read_i ? rd : '0;

    if (done && avs_write_i)
    begin
      case (avs_address_i)
        `TMC_A_CTRL:
        begin
          s_next.pre_en = avs_writedata_i[`TMC_CTRL_PRE_EN];
          s_next.pend_cfg = avs_writedata_i[`TMC_CTRL_CFG_LSB +: 3]; // see [R19]
          newcfg = avs_writedata_i[`TMC_CTRL_CFG_LSB +: 3];
          if (avs_writedata_i[`TMC_CTRL_FUNC_CLR] && s_reg.mode == TMC_FUNC)
            s_next.mode = TMC_RUN;
          if (avs_writedata_i[`TMC_CTRL_ENTER])
            s_next.mode = TMC_CFG; // see [R18]
          else if (avs_writedata_i[`TMC_CTRL_EXIT] && s_reg.mode == TMC_CFG)
          begin
            s_next.mode = TMC_RUN;
            s_next.cur_cfg = newcfg; // see [R19]
            if (newcfg != s_reg.cur_cfg)
            begin
              s_next.sv1 = '0; // see [R20]
              s_next.sv2 = '0; // see [R20]
            end
          end
        end
        `TMC_A_PRESCALE: s_next.prescale = avs_writedata_i[15:0];
        `TMC_A_SV1: s_next.sv1 = avs_writedata_i[23:0];
        `TMC_A_SV2: s_next.sv2 = avs_writedata_i[23:0];
        `TMC_A_TIMES:
        begin
          s_next.zt = avs_writedata_i[`TMC_TIMES_ZT_LSB +: 10];
          s_next.st = avs_writedata_i[`TMC_TIMES_ST_LSB +: 10];
        end
        `TMC_A_DISP:
        begin
          s_next.colour = tmc_colour_t'(avs_writedata_i[`TMC_DISP_COL_LSB +: 2]);
          s_next.dp = avs_writedata_i[`TMC_DISP_DP_LSB +: 3]; // see [R3]
          s_next.alloc = avs_writedata_i[`TMC_DISP_ALLOC];
          s_next.lock = avs_writedata_i[`TMC_DISP_LOCK_LSB +: 3];
        end
        default: ;
      endcase
    end

    // key holds; the operator keeps the keys down, we only time them
    if (keys_l.mode && !(prot_l && blk[0]))
    begin
      if (tenth && s_reg.hold_t != 10'h3ff)
        s_next.hold_t = s_reg.hold_t + 10'h1; // see [R17]
    end
    else
      s_next.hold_t = '0;
    // key entry after the bus so a key hold wins over a bus enter write in the same cycle
    if (s_reg.mode == TMC_RUN)
    begin
      if (keys_l.second && s_reg.hold_t >= `TMC_CFG_HOLD_TENTHS)
        s_next.mode = TMC_CFG; // see [R17] [R18]
      else if (!keys_l.second && s_reg.hold_t >= `TMC_FUNC_HOLD_TENTHS)
        s_next.mode = TMC_FUNC; // see [R17]
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      s_reg <= '0;
      s_reg.mode <= TMC_RUN;
      s_reg.dip <= tmc_dip_t'(`TMC_DIP_RST);
      s_reg.cur_cfg <= `TMC_CFG_TACH;
      s_reg.pend_cfg <= `TMC_CFG_TACH;
      s_reg.prescale <= `TMC_PRESCALE_RST;
      s_reg.zt <= `TMC_ZT_RST;
      s_reg.st <= `TMC_ST_RST;
      s_reg.lock <= `TMC_LOCK_RST;
      s_reg.red <= 1'b1;
      s_reg.waitreq <= 1'b1;
    end
    else
      s_reg <= s_next;
  end

  assign avs_readdata_o = s_reg.rdata;
  assign avs_waitrequest_o = s_reg.waitreq;
  assign keys_o = s_reg.keys;
  assign transistor_o = s_reg.trans;
  assign contact_o = s_reg.contact;
  assign red_o = s_reg.red;
  assign green_o = s_reg.green;
  assign protect_led_o = s_reg.led;
  assign decimal_point_position_o = s_reg.dp;
  assign value_o = s_reg.pv;

  property p_alloc;
    @(posedge clk_i) disable iff (!rst_n_i)
    transistor_o == $past(s_reg.alloc ? s_reg.control_output_two : s_reg.control_output_one);
  endproperty
  a_alloc: assert property (p_alloc) else $error("transistor stage not following allocation"); // see [R14]

  property p_cfg_off;
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.mode == TMC_CFG) [*3] |-> !transistor_o && !contact_o && value_o == 24'h0;
  endproperty
  a_cfg_off: assert property (p_cfg_off) else $error("outputs live in config mode"); // see [R18]

  property p_startup;
    @(posedge clk_i) disable iff (!rst_n_i)
    !s_reg.started |=> value_o == 24'h0 ##1 !s_reg.control_output_one && !s_reg.control_output_two;
  endproperty
  a_startup: assert property (p_startup) else $error("value shown during startup"); // see [R9]

  property p_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.zt != 10'h0 && s_reg.idle_t >= s_reg.zt && s_reg.mode != TMC_CFG) |=> value_o == 24'h0;
  endproperty
  a_zero: assert property (p_zero) else $error("auto-zero did not clear value"); // see [R8]

  property p_lock_mode;
    @(posedge clk_i) disable iff (!rst_n_i)
    $rose(prot_l) |=> protect_led_o && !keys_o.mode;
  endproperty
  a_lock_mode: assert property (p_lock_mode) else $error("mode key passed while protected"); // see [R15] [R16]

  property p_lock5;
    @(posedge clk_i) disable iff (!rst_n_i)
    prot_l && s_reg.lock == 3'h5 |=> !keys_o.mode && !keys_o.rst && !keys_o.updown && !keys_o.disp;
  endproperty
  a_lock5: assert property (p_lock5) else $error("level five left a key open"); // see [R16]

  property p_colour_area;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_reg.colour == TMC_DYN && s_reg.dip.omode == TMC_AREA && !s_reg.control_output_one |=> red_o && !green_o;
  endproperty
  a_colour_area: assert property (p_colour_area) else $error("area colour not from output one"); // see [R13]

  property p_colour_inv;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_reg.colour == TMC_DYN_INV && s_reg.dip.omode != TMC_AREA && (s_reg.control_output_one || s_reg.control_output_two) |=> red_o;
  endproperty
  a_colour_inv: assert property (p_colour_inv) else $error("inverse colour wrong"); // see [R12]

  property p_cfg_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
    done && avs_write_i && avs_address_i == `TMC_A_CTRL && avs_writedata_i[`TMC_CTRL_EXIT]
      && !avs_writedata_i[`TMC_CTRL_ENTER] && s_reg.mode == TMC_CFG
      && avs_writedata_i[`TMC_CTRL_CFG_LSB +: 3] != s_reg.cur_cfg
      |=> s_reg.sv1 == 24'h0 && s_reg.sv2 == 24'h0 && s_reg.mode == TMC_RUN;
  endproperty
  a_cfg_clear: assert property (p_cfg_clear) else $error("setpoints kept over config change"); // see [R19] [R20]

  property p_window;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_reg.live && $changed(s_reg.pv) && s_reg.pv != 24'h0 |-> $past(win_end);
  endproperty
  a_window: assert property (p_window) else $error("value changed off a window edge"); // see [R7] [R24]

  property p_bus;
    @(posedge clk_i) disable iff (!rst_n_i)
    req && avs_waitrequest_o |=> !avs_waitrequest_o ##1 avs_waitrequest_o;
  endproperty
  a_bus: assert property (p_bus) else $error("waitrequest not one cycle"); // bus handshake chosen here, see header
endmodule
`default_nettype wire
